// ---- include/byte_op_defines.svh ----
// constants for the byte-oriented execute block
// assumes a 16-bit program word and a 12-bit data file address
`ifndef BYTE_OP_DEFINES_SVH
`define BYTE_OP_DEFINES_SVH
// full 6-bit opcodes, bits 15:10
`define OPC_ADD 6'h09
`define OPC_ADDC 6'h08
`define OPC_SUB 6'h17
`define OPC_SUBB 6'h16
`define OPC_SUBFB 6'h15
`define OPC_AND 6'h05
`define OPC_OR 6'h04
`define OPC_XOR 6'h06
`define OPC_COM 6'h07
`define OPC_DECSZ 6'h0b
`define OPC_INCSZ 6'h0f
`define OPC_DECSNZ 6'h13
`define OPC_INCSNZ 6'h12
`define OPC_RLC 6'h0d
`define OPC_RRC 6'h0c
`define OPC_RLN 6'h11
`define OPC_RRN 6'h10
// 7-bit opcodes, bits 15:9, no destination bit
`define OPC_CPEQ 7'h31
`define OPC_CPGT 7'h32
`define OPC_CPLT 7'h30
`define OPC_MUL 7'h01
// two-word move prefixes, bits 15:12
`define PFX_MOVE_SRC 4'hc
`define PFX_MOVE_DST 4'hf
// access bank split and indexed window
`define ACC_SPLIT 8'h60
`define IDX_LIMIT 8'h5f
`define ACC_LOW_BANK 4'h0
`define ACC_HIGH_BANK 4'hf
// special file addresses
`define PORT_B_ADDR 12'hf81
`define TIMER0_ADDR 12'hfd6
// status flag positions
`define FLG_C 0
`define FLG_DC 1
`define FLG_Z 2
`define FLG_OV 3
`define FLG_N 4
// register map, byte offsets
`define OFS_CTRL 8'h00
`define OFS_BANK 8'h04
`define OFS_INDEX 8'h08
`define OFS_WORK 8'h0c
`define OFS_STATUS 8'h10
`define OFS_PROD 8'h14
`define CTRL_EXT_BIT 0
`define CTRL_PSA_BIT 1
// reset values
`define RST_WORK 8'h00
`define RST_FLAGS 5'h00
`define RST_CTRL 2'h0
`define RST_BANK 4'h0
`define RST_INDEX 12'h000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- include/byte_op_pkg.sv ----
// types for the byte-oriented execute block
// assumes byte_op_defines.svh holds the numbers
package byte_op_pkg;
    typedef enum {
        op_nop, op_add, op_addc, op_sub, op_subb, op_subfb, op_and, op_or,
        op_xor, op_com, op_decsz, op_incsz, op_decsnz, op_incsnz, op_cpeq,
        op_cpgt, op_cplt, op_rlc, op_rrc, op_rln, op_rrn, op_file_to_file_move, op_mul
    } op_t;
    // one byte-oriented program word
    typedef struct packed {
        logic [5:0] opcode;
        logic dest;
        logic access;
        logic [7:0] file;
    } instr_t;
    // alu answer
    typedef struct packed {
        logic [7:0] res;
        logic [4:0] flags;
        logic wr;
        logic skip;
    } alu_t;
endpackage : byte_op_pkg

// ---- hw/byte_op_instruction_exec.sv ----
// byte-oriented instruction execute unit with its own data file and registers
// assumes one program word per cycle from an outside fetcher, AXI4-Lite for control
// Summary of operation
// - add prefix 0010: 01da w+f, 00da w+f+carry; all five flags
// - subtract prefix 0101: 11da f-w, 10da f-w-borrow, 01da w-f-borrow
// - logic prefix 0001: and, or, xor, complement; only zero and negative
// - dec/inc skip on zero or non-zero; no flags; skip costs cycles
// - compare prefix 0110: skip on equal, greater, less; no flags
// - rotate through carry prefix 0011, left 01da, right 00da; C, Z, N
// - 0100 00da rotates right, bit 0 into bit 7; Z and N
// - 0100 01da rotates left, bit 7 into bit 0; Z and N
// - destination bit 0 writes working register, 1 writes file register
// - access bit 0 uses access bank, 1 uses bank select register
// - access 0 with extended set uses indexed offset for f up to 95
// - file-to-file move: two words 1100 source, 1111 destination; no flags
// - multiply working register by file register; flags unchanged
// - read-modify of port register uses pin levels as operand
// - writing first timer count clears prescaler when assigned
// - taken skip costs an extra cycle run as no-operation, two when it skips a two-word move
// - stray second word of a two-word instruction runs as no-operation
`include "byte_op_defines.svh"

module byte_op_instruction_exec (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [7:0] port_b_pins,
    output logic nop_cycle,
    output logic prescaler_clear,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] file_mem [0:4095];
    logic [7:0] working_register_r;
    logic [4:0] flags_r;
    logic [15:0] prod_r;
    logic [1:0] ctrl_r;
    logic [3:0] bank_select_register_r;
    logic [11:0] index_base_r;
    logic skip_r;
    logic pend_r;
    logic [11:0] src_r;
    logic [7:0] pb_meta_r;
    logic [7:0] pb_sync_r;
    byte_op_pkg::instr_t ins;
    byte_op_pkg::op_t op;
    byte_op_pkg::alu_t alu;
    logic [11:0] eff_addr;
    logic [11:0] rd_addr;
    logic [7:0] operand;
    logic exec;
    logic move_wr;
    logic file_we;
    logic [11:0] wr_addr;
    logic [7:0] wr_data;

    // 8-bit add returning {carry, digit carry, overflow, sum}
    function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                         input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {s[8], h[4], (a[7] == b[7]) && (s[7] != a[7]), s[7:0]};
    endfunction : add8

    // opcode to operation
    function automatic byte_op_pkg::op_t decode(input logic [15:0] w);
        decode = byte_op_pkg::op_nop;
        case (w[15:10])
            `OPC_ADD: decode = byte_op_pkg::op_add;
            `OPC_ADDC: decode = byte_op_pkg::op_addc;
            `OPC_SUB: decode = byte_op_pkg::op_sub;
            `OPC_SUBB: decode = byte_op_pkg::op_subb;
            `OPC_SUBFB: decode = byte_op_pkg::op_subfb;
            `OPC_AND: decode = byte_op_pkg::op_and;
            `OPC_OR: decode = byte_op_pkg::op_or;
            `OPC_XOR: decode = byte_op_pkg::op_xor;
            `OPC_COM: decode = byte_op_pkg::op_com;
            `OPC_DECSZ: decode = byte_op_pkg::op_decsz;
            `OPC_INCSZ: decode = byte_op_pkg::op_incsz;
            `OPC_DECSNZ: decode = byte_op_pkg::op_decsnz;
            `OPC_INCSNZ: decode = byte_op_pkg::op_incsnz;
            `OPC_RLC: decode = byte_op_pkg::op_rlc;
            `OPC_RRC: decode = byte_op_pkg::op_rrc;
            `OPC_RLN: decode = byte_op_pkg::op_rln;
            `OPC_RRN: decode = byte_op_pkg::op_rrn;
            default: ;
        endcase
        case (w[15:9])
            `OPC_CPEQ: decode = byte_op_pkg::op_cpeq;
            `OPC_CPGT: decode = byte_op_pkg::op_cpgt;
            `OPC_CPLT: decode = byte_op_pkg::op_cplt;
            `OPC_MUL: decode = byte_op_pkg::op_mul;
            default: ;
        endcase
        if (w[15:12] == `PFX_MOVE_SRC) begin
            decode = byte_op_pkg::op_file_to_file_move;
        end
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////
    // decode and addressing
    assign ins = instr_word;
    assign op = decode(instr_word);

    // banked, access or indexed address of the word's file operand
    always_comb begin
        if (ins.access) begin
            eff_addr = {bank_select_register_r, ins.file};
        end else if (ctrl_r[`CTRL_EXT_BIT] && ins.file <= `IDX_LIMIT) begin
            eff_addr = index_base_r + {4'h0, ins.file};
        end else if (ins.file < `ACC_SPLIT) begin
            eff_addr = {`ACC_LOW_BANK, ins.file};
        end else begin
            eff_addr = {`ACC_HIGH_BANK, ins.file};
        end
    end

    // a skipped word, or a second move word not preceded by its first, is a nop
    assign move_wr = instr_valid && pend_r && !skip_r
        && instr_word[15:12] == `PFX_MOVE_DST;
    assign exec = instr_valid && !skip_r && !move_wr
        && instr_word[15:12] != `PFX_MOVE_DST;
    assign rd_addr = move_wr ? src_r : eff_addr;
    // pins, not the output latch, feed a port read-modify-write
    assign operand = (rd_addr == `PORT_B_ADDR) ? pb_sync_r : file_mem[rd_addr];

    ////////////////////////////////////////////////////////////////////////
    // alu: result, flags, write and skip decisions
    always_comb begin
        logic [10:0] sum;
        logic [7:0] w;
        sum = 11'h000;
        w = working_register_r;
        alu.res = operand;
        alu.flags = flags_r;
        alu.wr = 1'b1;
        alu.skip = 1'b0;
        unique case (op)
            byte_op_pkg::op_add: sum = add8(w, operand, 1'b0);
            byte_op_pkg::op_addc: sum = add8(w, operand, flags_r[`FLG_C]);
            byte_op_pkg::op_sub: sum = add8(operand, ~w, 1'b1);
            byte_op_pkg::op_subb: sum = add8(operand, ~w, flags_r[`FLG_C]);
            byte_op_pkg::op_subfb: sum = add8(w, ~operand, flags_r[`FLG_C]);
            byte_op_pkg::op_and: alu.res = w & operand;
            byte_op_pkg::op_or: alu.res = w | operand;
            byte_op_pkg::op_xor: alu.res = w ^ operand;
            byte_op_pkg::op_com: alu.res = ~operand;
            byte_op_pkg::op_decsz, byte_op_pkg::op_decsnz: begin
                alu.res = operand - 8'h01;
                alu.skip = (alu.res == 8'h00) == (op == byte_op_pkg::op_decsz);
            end
            byte_op_pkg::op_incsz, byte_op_pkg::op_incsnz: begin
                alu.res = operand + 8'h01;
                alu.skip = (alu.res == 8'h00) == (op == byte_op_pkg::op_incsz);
            end
            byte_op_pkg::op_cpeq, byte_op_pkg::op_cpgt, byte_op_pkg::op_cplt: begin
                alu.wr = 1'b0;
                alu.skip = (op == byte_op_pkg::op_cpeq) ? operand == w
                    : (op == byte_op_pkg::op_cpgt) ? operand > w : operand < w;
            end
            byte_op_pkg::op_rlc: begin
                alu.res = {operand[6:0], flags_r[`FLG_C]};
                alu.flags[`FLG_C] = operand[7];
            end
            byte_op_pkg::op_rrc: begin
                alu.res = {flags_r[`FLG_C], operand[7:1]};
                alu.flags[`FLG_C] = operand[0];
            end
            byte_op_pkg::op_rln: alu.res = {operand[6:0], operand[7]};
            byte_op_pkg::op_rrn: alu.res = {operand[0], operand[7:1]};
            byte_op_pkg::op_mul, byte_op_pkg::op_file_to_file_move, byte_op_pkg::op_nop: begin
                alu.wr = 1'b0;
            end
        endcase
        // arithmetic class: all five flags
        if (op inside {byte_op_pkg::op_add, byte_op_pkg::op_addc, byte_op_pkg::op_sub,
                       byte_op_pkg::op_subb, byte_op_pkg::op_subfb}) begin
            alu.res = sum[7:0];
            alu.flags[`FLG_C] = sum[10];
            alu.flags[`FLG_DC] = sum[9];
            alu.flags[`FLG_OV] = sum[8];
        end
        // logic and plain rotates touch zero and negative only; rotates through carry also set carry
        if (op inside {byte_op_pkg::op_add, byte_op_pkg::op_addc, byte_op_pkg::op_sub,
                       byte_op_pkg::op_subb, byte_op_pkg::op_subfb, byte_op_pkg::op_and,
                       byte_op_pkg::op_or, byte_op_pkg::op_xor, byte_op_pkg::op_com,
                       byte_op_pkg::op_rlc, byte_op_pkg::op_rrc, byte_op_pkg::op_rln,
                       byte_op_pkg::op_rrn}) begin
            alu.flags[`FLG_Z] = alu.res == 8'h00;
            alu.flags[`FLG_N] = alu.res[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // file write port: alu result with dest 1, or the move's second word
    assign file_we = move_wr || (exec && alu.wr && ins.dest);
    assign wr_addr = move_wr ? instr_word[11:0] : eff_addr;
    assign wr_data = move_wr ? operand : alu.res;

    // no reset on the array, so it maps to plain ram
    always_ff @(posedge aclk) begin
        if (file_we) begin
            file_mem[wr_addr] <= wr_data;
        end
    end

    // working register, flags and product
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            working_register_r <= `RST_WORK;
            flags_r <= `RST_FLAGS;
            prod_r <= 16'h0000;
        end else if (exec) begin
            flags_r <= alu.flags;
            if (alu.wr && !ins.dest) begin
                working_register_r <= alu.res;
            end
            if (op == byte_op_pkg::op_mul) begin
                prod_r <= {8'h00, working_register_r} * {8'h00, operand};
            end
        end
    end

    // skip and two-word tracking; a skipped first move word leaves its
    // second word to run as a stray nop, giving the three-cycle skip
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            skip_r <= 1'b0;
            pend_r <= 1'b0;
            src_r <= 12'h000;
        end else if (instr_valid) begin
            skip_r <= exec && alu.skip;
            pend_r <= exec && op == byte_op_pkg::op_file_to_file_move;
            if (exec && op == byte_op_pkg::op_file_to_file_move) begin
                src_r <= instr_word[11:0];
            end
        end
    end

    // status pulses and pin synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nop_cycle <= 1'b0;
            prescaler_clear <= 1'b0;
            pb_meta_r <= 8'h00;
            pb_sync_r <= 8'h00;
        end else begin
            nop_cycle <= instr_valid && !exec && !move_wr;
            prescaler_clear <= file_we && wr_addr == `TIMER0_ADDR
                && ctrl_r[`CTRL_PSA_BIT];
            pb_meta_r <= port_b_pins;
            pb_sync_r <= pb_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; address and data held until both are in
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go;

    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = !w_have_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

    // write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r == `OFS_CTRL || aw_addr_r == `OFS_BANK
                    || aw_addr_r == `OFS_INDEX) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control registers, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `RST_CTRL;
            bank_select_register_r <= `RST_BANK;
            index_base_r <= `RST_INDEX;
        end else if (wr_go && w_strb_r[0]) begin
            if (aw_addr_r == `OFS_CTRL) begin
                ctrl_r <= w_data_r[1:0];
            end
            if (aw_addr_r == `OFS_BANK) begin
                bank_select_register_r <= w_data_r[3:0];
            end
            if (aw_addr_r == `OFS_INDEX) begin
                index_base_r[7:0] <= w_data_r[7:0];
            end
        end
        if (aresetn && wr_go && w_strb_r[1] && aw_addr_r == `OFS_INDEX) begin
            index_base_r[11:8] <= w_data_r[11:8];
        end
    end

    // read channel: one cycle to answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            unique case (s_axi_araddr)
                `OFS_CTRL: s_axi_rdata <= {30'h0, ctrl_r};
                `OFS_BANK: s_axi_rdata <= {28'h0, bank_select_register_r};
                `OFS_INDEX: s_axi_rdata <= {20'h0, index_base_r};
                `OFS_WORK: s_axi_rdata <= {24'h0, working_register_r};
                `OFS_STATUS: s_axi_rdata <= {27'h0, flags_r};
                `OFS_PROD: s_axi_rdata <= {16'h0, prod_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic do_w;
    assign do_w = exec && !ins.dest;

    add_result_a: assert property (do_w && op == byte_op_pkg::op_add |=>
        working_register_r == 8'($past(working_register_r) + $past(operand)))
        else $error("add result wrong");
    sub_result_a: assert property (do_w && op == byte_op_pkg::op_sub |=>
        working_register_r == 8'($past(operand) - $past(working_register_r)))
        else $error("subtract result wrong");
    logic_flags_a: assert property (exec && op == byte_op_pkg::op_and |=>
        flags_r[`FLG_C] == $past(flags_r[`FLG_C]) && $stable(flags_r[`FLG_OV]))
        else $error("logic op touched carry or overflow");
    skip_zero_a: assert property (exec && op == byte_op_pkg::op_decsz
        && operand == 8'h01 ##1 instr_valid |-> !exec ##1 !skip_r)
        else $error("decrement skip not taken");
    compare_keep_a: assert property (exec && op == byte_op_pkg::op_cpgt |=>
        $stable(flags_r) && $stable(working_register_r)
        && skip_r == ($past(operand) > $past(working_register_r)))
        else $error("compare misbehaved");
    rotate_right_a: assert property (do_w && op == byte_op_pkg::op_rrn |=>
        working_register_r == {$past(operand[0]), $past(operand[7:1])})
        else $error("plain rotate right wrong");
    dest_file_a: assert property (exec && ins.dest |=>
        $stable(working_register_r))
        else $error("dest 1 changed working register");
    mul_flags_a: assert property (exec && op == byte_op_pkg::op_mul |=>
        $stable(flags_r) && prod_r == $past(working_register_r) * $past(operand))
        else $error("multiply wrong");
    prescaler_a: assert property (file_we && wr_addr == `TIMER0_ADDR
        && ctrl_r[`CTRL_PSA_BIT] |=> prescaler_clear ##1 !prescaler_clear || $past(file_we))
        else $error("prescaler not cleared");
    stray_word_a: assert property (instr_valid && !pend_r
        && instr_word[15:12] == `PFX_MOVE_DST |=> nop_cycle && $stable(flags_r))
        else $error("stray second word executed");

    move_c: cover property (exec && op == byte_op_pkg::op_file_to_file_move ##1 move_wr);
    skip_two_word_c: cover property (skip_r && instr_valid
        && instr_word[15:12] == `PFX_MOVE_SRC);
    indexed_c: cover property (exec && !ins.access && ctrl_r[`CTRL_EXT_BIT]);
    port_read_c: cover property (exec && rd_addr == `PORT_B_ADDR);
endmodule : byte_op_instruction_exec

// ---- bench/prog_mem_model.sv ----
// program memory model that streams words to the instruction port
// assumes the bench fills mem and pulses start with the word count
module prog_mem_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic [3:0] len,
    input wire logic slow,
    output logic instr_valid,
    output logic [15:0] instr_word,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [3:0] pc_r;
    logic [3:0] left_r;
    logic gap_r;
    ////////////////////////////////////////////////////////////////
    // idle word changes so a stale word never looks fresh
    assign busy = left_r != 4'h0;
    assign instr_valid = busy && !gap_r;
    assign instr_word = instr_valid ? mem[pc_r] : {pc_r, ~pc_r, pc_r, ~pc_r};
    // slow mode leaves one idle cycle between words
    always_ff @(posedge aclk) begin
        if (!aresetn || start) begin
            pc_r <= 4'h0;
            left_r <= start ? len : 4'h0;
            gap_r <= 1'b0;
        end else if (busy) begin
            gap_r <= slow && !gap_r;
            if (instr_valid) begin
                pc_r <= pc_r + 4'h1;
                left_r <= left_r - 4'h1;
            end
        end
    end
endmodule : prog_mem_model

// ---- bench/byte_op_instruction_exec_test.sv ----
// self-checking bench for the byte-oriented execute block
// assumes the program memory model and AXI4-Lite register access
`include "byte_op_defines.svh"
module byte_op_instruction_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, start = 1'b0, slow = 1'b0;
    logic instr_valid, busy, nop_cycle, prescaler_clear;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] instr_word;
    logic [3:0] len = 4'h0, s_axi_wstrb = 4'hf;
    logic [7:0] port_b_pins = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] w, seed;
    logic [4:0] fl;
    int err_count = 0, n_checks = 0, nops = 0, clears = 0;
    localparam logic [5:0] ops [13] = '{`OPC_ADD, `OPC_ADDC, `OPC_SUB, `OPC_SUBB, `OPC_SUBFB,
        `OPC_AND, `OPC_OR, `OPC_XOR, `OPC_COM, `OPC_RLC, `OPC_RRC, `OPC_RLN, `OPC_RRN};
    always #4 aclk = ~aclk;
    byte_op_instruction_exec dut (.aclk, .aresetn, .instr_valid, .instr_word, .port_b_pins,
        .nop_cycle, .prescaler_clear, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    prog_mem_model prog (.aclk, .aresetn, .start, .len, .slow, .instr_valid, .instr_word, .busy);
    // one-cycle pulses, each counted once
    always @(posedge aclk) begin
        if (nop_cycle === 1'b1) nops++;
        if (prescaler_clear === 1'b1) clears++;
    end
    ////////////////////////////////////////////////////////////////
    // reference alu: carry-style adder covers add and the three subtracts
    function automatic logic [12:0] model(input logic [5:0] op, input logic [7:0] w, f,
                                          input logic [4:0] fl);
        logic [7:0] x, y, r;
        logic ci;
        logic [8:0] s;
        logic [4:0] o;
        o = fl;
        x = (op == `OPC_SUBFB) ? w : f;
        y = (op == `OPC_SUBFB) ? ~f : (op inside {`OPC_SUB, `OPC_SUBB}) ? ~w : w;
        ci = op == `OPC_SUB || (op != `OPC_ADD && fl[0]);
        s = {1'b0, x} + y + ci;
        r = s[7:0];
        case (op)
            `OPC_ADD, `OPC_ADDC, `OPC_SUB, `OPC_SUBB, `OPC_SUBFB: begin
                o[0] = s[8];
                o[1] = ({1'b0, x[3:0]} + y[3:0] + ci) > 5'h0f;
                o[3] = (x[7] == y[7]) && (r[7] != x[7]);
            end
            `OPC_AND: r = w & f;
            `OPC_OR: r = w | f;
            `OPC_XOR: r = w ^ f;
            `OPC_COM: r = ~f;
            `OPC_RLC: begin
                r = {f[6:0], fl[0]};
                o[0] = f[7];
            end
            `OPC_RRC: begin
                r = {fl[0], f[7:1]};
                o[0] = f[0];
            end
            `OPC_RLN: r = {f[6:0], f[7]};
            default: r = {f[0], f[7:1]};
        endcase
        o[2] = r == 8'h00;
        o[4] = r[7];
        return {o, r};
    endfunction : model
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    ////////////////////////////////////////////////////////////////
    // bus cycles: each channel is held until its own ready
    task automatic axi_rd(input logic [7:0] ad);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask : axi_rd
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
    endtask : axi_wr
    // stream n words, then let the last result land
    task automatic run(input logic [3:0] n, input logic s);
        len <= n;
        slow <= s;
        start <= 1'b1;
        @(posedge aclk);
        start <= 1'b0;
        do @(posedge aclk); while (busy);
        repeat (2) @(posedge aclk);
    endtask : run
    // pins pass two flops: wait before the move
    task automatic load(input logic [7:0] v, input logic [11:0] dst, input logic s);
        port_b_pins <= v;
        repeat (3) @(posedge aclk);
        prog.mem[0] = {4'hc, 12'hf81};
        prog.mem[1] = {4'hf, dst};
        run(4'h2, s);
    endtask : load
    task automatic op(input logic [5:0] opc, input logic ab, input logic [7:0] f, fv);
        prog.mem[0] = {opc, 1'b0, ab, f};
        run(4'h1, 1'b0);
        {fl, w} = model(opc, w, fv, fl);
        axi_rd(8'h0c);
        chk(rd, {24'h0, w});
        axi_rd(8'h10);
        chk(rd, {27'h0, fl});
    endtask : op
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////
    // cut a hang well past the run's length
    initial begin
        #100000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        w = 8'h00;
        fl = 5'h00;
        seed = 8'h5a;
        axi_rd(8'h1c);
        chk(rs, `RESP_SLVERR);
        axi_wr(8'h0c, 32'hff);
        chk(rs, `RESP_SLVERR);
        for (int i = 0; i < 13; i++) begin
            seed = lfsr(seed);
            load(seed, 12'h010, i[0]);
            op(ops[i], 1'b0, 8'h10, seed);
        end
        prog.mem[0] = {`OPC_MUL, 1'b0, 8'h10};
        run(4'h1, 1'b0);
        axi_rd(8'h14);
        chk(rd, {24'h0, w} * {24'h0, seed});
        axi_rd(8'h10);
        chk(rd, {27'h0, fl});
        axi_wr(8'h04, 32'hf);
        op(`OPC_OR, 1'b1, 8'h81, seed);
        axi_wr(8'h08, 32'hf71);
        axi_wr(8'h00, 32'h1);
        op(`OPC_XOR, 1'b0, 8'h10, seed);
        axi_wr(8'h00, 32'h2);
        load(8'h01, 12'h010, 1'b0);
        // timer write, skips on zero, non-zero and compare, a stray second word
        prog.mem[1] = {4'hf, 12'hfd6};
        prog.mem[2] = {`OPC_DECSZ, 1'b1, 1'b0, 8'h10};
        prog.mem[3] = {`OPC_XOR, 1'b0, 1'b0, 8'h81};
        prog.mem[4] = {4'hf, 12'h010};
        prog.mem[5] = {`OPC_INCSNZ, 2'b10, 8'h10};
        prog.mem[6] = prog.mem[3];
        prog.mem[7] = {`OPC_DECSNZ, 2'b00, 8'h10};
        prog.mem[8] = {`OPC_CPGT, 1'b0, 8'h10};
        prog.mem[9] = prog.mem[3];
        w = 8'h00;
        run(4'ha, 1'b1);
        chk(nops, 4);
        chk(clears, 1);
        axi_rd(8'h0c);
        chk(rd, {24'h0, w});
        axi_rd(8'h10);
        chk(rd, {27'h0, fl});
        summarize();
    end
endmodule : byte_op_instruction_exec_test
